// file: pkg/dcrb_pkg.sv
// package: register addresses, field positions, reset values and frame layout for the output converter register bank
package dcrb_pkg;
  // ****************************************************************
  // frame layout: 8-bit address then 16-bit data
  // ****************************************************************
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;
  localparam int FRAME_WIDTH = 24;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_OUTPUT_CODE = 8'h01;
  localparam logic [7:0] ADDR_READBACK = 8'h02;
  localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h55;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h56;
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h57;
  localparam logic [7:0] ADDR_GAIN_CAL = 8'h58;
  localparam logic [7:0] ADDR_OFFSET_CAL = 8'h59;

  // readback selectors (low bits of a readback frame's data)
  localparam logic [7:0] RB_STATUS = 8'h00;
  localparam logic [7:0] RB_OUTPUT_CODE = 8'h01;
  localparam logic [7:0] RB_OUTPUT_CONTROL = 8'h02;
  localparam logic [7:0] RB_DEVICE_CONFIG = 8'h0b;
  localparam logic [7:0] RB_GAIN_CAL = 8'h13;
  localparam logic [7:0] RB_OFFSET_CAL = 8'h17;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTL_CLEAR_SEL_BIT = 15;
  localparam int CTL_OUTPUT_EN_BIT = 12;
  localparam int CTL_RANGE_HI = 2;
  localparam int CTL_RANGE_LO = 0;

  // ****************************************************************
  // configuration register fields
  // ****************************************************************
  localparam logic [15:0] CFG_WRITE_MASK = 16'h07bf;
  localparam int CFG_CUR_RANGE_HI = 10;
  localparam int CFG_CUR_RANGE_LO = 9;
  localparam int CFG_DUAL_EN_BIT = 8;
  localparam int CFG_SENSE_PD_BIT = 7;
  localparam int CFG_CAL_EN_BIT = 5;
  localparam int CFG_MODEM_EN_BIT = 4;
  localparam int CFG_FRAME_CHECK_BIT = 3;
  localparam int CFG_TIMEOUT_EN_BIT = 2;
  localparam int RESET_BIT = 0;

  // ****************************************************************
  // reset values and range codes
  // ****************************************************************
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CAL_RESET = 16'h0000;
  localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [1:0] CUR_RANGE_4_20 = 2'h1;
  localparam logic [4:0] STATUS_WIDTH = 5'h05;
endpackage

// file: pkg/dcrb_link_if.sv
// interface: parallel frame link between host controller and register bank
`timescale 1ns/100ps
interface dcrb_link_if;
  logic        frame_valid;   // one-cycle strobe: frame complete
  logic [23:0] frame_data;    // address in 23:16, data in 15:0
  logic        frame_error;   // frame failed its check
  logic [15:0] read_data;     // readback word
  logic        read_valid;    // one-cycle strobe with read_data

  modport device (input frame_valid, input frame_data, input frame_error, output read_data, output read_valid);
  modport host (output frame_valid, output frame_data, output frame_error, input read_data, input read_valid);
endinterface

// file: hw/dcrb_code_path.sv
// module: calibration adjust of the shared output code
`timescale 1ns/100ps
module dcrb_code_path
  import dcrb_pkg::*;
#(
  parameter int CODE_BITS = 16
)
(
  input  wire logic        calibration_enable,  // adjust when high
  input  wire logic [15:0] code_in,             // raw output code
  input  wire logic [15:0] gain_trim_bits,      // unsigned gain
  input  wire logic [15:0] offset_trim_bits,    // two's complement offset
  output logic      [15:0] code_out             // adjusted code
);
  logic [32:0] scaled;
  logic signed [18:0] sum;
  logic [15:0] low_mask;

  assign low_mask = 16'hffff << (16 - CODE_BITS);

  // gain scales by (1 + g/65536) then offset is added, clamped to range
  always_comb
  begin
    scaled = {17'h00000, code_in} * {17'h00001, gain_trim_bits};
    sum = $signed({3'h0, scaled[31:16]}) + 19'(signed'(offset_trim_bits));
    if (!calibration_enable)
      code_out = code_in & low_mask;
    else if (scaled[32] || sum > 19'sh0ffff)
      code_out = 16'hffff & low_mask;
    else if (sum < 19'sh0)
      code_out = CODE_ZERO;
    else
      code_out = sum[15:0] & low_mask;
  end
endmodule

// file: hw/dcrb_device.sv
// module: register bank of the programmable voltage/current output converter
// ****************************************************************
// Functional notes
// - control register lives at address 0x55
// - configuration register lives at address 0x57
// - host writes zeros to reserved configuration bits
// - current range used only with dual output
// - voltage range always from control range field
// - current range coded like main range low bits
// - current range change keeps output code
// - dual enable turns on both outputs
// - both outputs share one output code
// - sense power-down bit grounds sense node
// - calibration enable applies gain and offset
// - modem coupling only in 4-20 mA range
// - configuration bit three enables frame checking
// - output code sixteen bits, resets zero
// - twelve-bit variant ignores low four bits
// - gain register sixteen bits unsigned, resets zero
// - offset register two's complement, resets zero
// - reset register lives at address 0x56
// - reset register upper bits do nothing
// - reset bit restores registers and alarms
// - reset bit clears itself afterwards
// - range change clears code per clear select
// - alarms clear on resets or fault removal
// ****************************************************************
`timescale 1ns/100ps
module dcrb_device
  import dcrb_pkg::*;
#(
  parameter int CODE_BITS = 16
)
(
  input  wire logic        clk,                      // 50 MHz clock
  input  wire logic        reset_n,                  // synchronous reset
  dcrb_link_if.device      link,                     // frame link
  input  wire logic        fault_current,            // open or compliance fault
  input  wire logic        fault_thermal,            // over-temperature
  input  wire logic        fault_timeout,            // timeout monitor expired
  output logic             voltage_output_enable,    // voltage output on
  output logic             current_output_enable,    // current output on
  output logic [2:0]       voltage_range,            // voltage range code
  output logic [1:0]       current_range,            // current range code
  output logic             sense_power_down,         // ground sense node
  output logic             modem_coupling_active,    // modulate current output
  output logic             timeout_monitor_enable,   // to timeout monitor
  output logic [1:0]       timeout_period_select,    // to timeout monitor
  output logic [15:0]      converter_code,           // code to both outputs
  output logic [4:0]       alarm_status              // alarm bits
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] control_reg;
  logic [15:0] config_reg;
  logic [15:0] code_reg;
  logic [15:0] gain_reg;
  logic [15:0] offset_reg;
  logic        soft_reset_reg;
  logic        check_fault_reg;
  logic [15:0] adjusted_code;
  logic [15:0] low_mask;
  logic        accept;
  logic        write_ok;
  logic [7:0]  frame_addr;
  logic [15:0] frame_word;
  logic        range_change;
  logic        dual_on;
  logic [1:0]  eff_cur_range;
  logic [2:0]  fault_meta_reg;
  logic [2:0]  fault_sync_reg;

  assign low_mask = 16'hffff << (16 - CODE_BITS);
  assign frame_addr = link.frame_data[23:16];
  assign frame_word = link.frame_data[15:0];
  // a frame with a failed check is dropped only while checking is on
  assign accept = link.frame_valid && !(config_reg[CFG_FRAME_CHECK_BIT] && link.frame_error);
  assign write_ok = accept && !soft_reset_reg;
  assign range_change = write_ok && frame_addr == ADDR_OUTPUT_CONTROL
                        && frame_word[CTL_RANGE_HI:CTL_RANGE_LO] != control_reg[CTL_RANGE_HI:CTL_RANGE_LO];
  assign dual_on = config_reg[CFG_DUAL_EN_BIT];
  // in single mode the current range follows the main range low bits
  assign eff_cur_range = dual_on ? config_reg[CFG_CUR_RANGE_HI:CFG_CUR_RANGE_LO]
                                 : control_reg[CTL_RANGE_LO+1:CTL_RANGE_LO];

  function automatic logic [15:0] clear_code(input logic sel, input logic [2:0] rng);
    // clear select high: midscale for unipolar, zero code (negative full scale) for bipolar; select low: the reverse
    if (!sel)
      clear_code = (rng == 3'h2 || rng == 3'h3) ? CODE_MIDSCALE : CODE_ZERO;
    else
      clear_code = (rng == 3'h2 || rng == 3'h3) ? CODE_ZERO : CODE_MIDSCALE;
  endfunction

  // ****************************************************************
  // soft reset: one-cycle pulse, cleared by hardware
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      soft_reset_reg <= 1'b0;
    else if (soft_reset_reg)
      soft_reset_reg <= 1'b0;
    else if (accept && frame_addr == ADDR_SOFT_RESET)
      soft_reset_reg <= frame_word[RESET_BIT];
  end

  // ****************************************************************
  // control and configuration
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      control_reg <= CONTROL_RESET;
    else if (write_ok && frame_addr == ADDR_OUTPUT_CONTROL)
      control_reg <= frame_word;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      config_reg <= CONFIG_RESET;
    else if (write_ok && frame_addr == ADDR_DEVICE_CONFIG)
      config_reg <= frame_word & CFG_WRITE_MASK;                          // reserved bits kept zero
  end

  // ****************************************************************
  // code and calibration registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      code_reg <= CODE_RESET;
    else if (range_change)
      code_reg <= clear_code(frame_word[CTL_CLEAR_SEL_BIT], frame_word[2:0]) & low_mask;
    else if (write_ok && frame_addr == ADDR_OUTPUT_CODE)
      code_reg <= frame_word & low_mask;
    // configuration writes never touch the code
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      gain_reg <= CAL_RESET;
    else if (write_ok && frame_addr == ADDR_GAIN_CAL)
      gain_reg <= frame_word & low_mask;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      offset_reg <= CAL_RESET;
    else if (write_ok && frame_addr == ADDR_OFFSET_CAL)
      offset_reg <= frame_word & low_mask;
  end

  // ****************************************************************
  // alarms: live fault levels; frame check fault holds until reset or the next accepted frame
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      check_fault_reg <= 1'b0;
    else if (link.frame_valid && config_reg[CFG_FRAME_CHECK_BIT] && link.frame_error)
      check_fault_reg <= 1'b1;
    else if (accept)
      check_fault_reg <= 1'b0;                                            // good frame resolves it
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_reset_reg)
      alarm_status <= 5'h00;
    else
      alarm_status <= {check_fault_reg, fault_sync_reg[2], fault_sync_reg[1], 1'b0, fault_sync_reg[0]};
  end

  // fault levels come from the analog monitors, so two flops before use
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_meta_reg <= 3'h0;
      fault_sync_reg <= 3'h0;
    end
    else
    begin
      fault_meta_reg <= {fault_timeout, fault_current, fault_thermal};
      fault_sync_reg <= fault_meta_reg;
    end
  end

  // ****************************************************************
  // readback: selector in low byte of a frame to the readback address
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      link.read_valid <= 1'b0;
      link.read_data <= 16'h0000;
    end
    else
    begin
      link.read_valid <= accept && frame_addr == ADDR_READBACK;
      if (accept && frame_addr == ADDR_READBACK)
        case (frame_word[7:0])
          RB_STATUS:         link.read_data <= {11'h000, alarm_status};
          RB_OUTPUT_CODE:    link.read_data <= code_reg;
          RB_OUTPUT_CONTROL: link.read_data <= control_reg;
          RB_DEVICE_CONFIG:  link.read_data <= config_reg;
          RB_GAIN_CAL:       link.read_data <= gain_reg;
          RB_OFFSET_CAL:     link.read_data <= offset_reg;
          default:           link.read_data <= 16'h0000;
        endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  dcrb_code_path #(
    .CODE_BITS (CODE_BITS)
  ) dcrb_code_path_inst (
    .calibration_enable (config_reg[CFG_CAL_EN_BIT]),
    .code_in            (code_reg),                                       // one shared code
    .gain_trim_bits     (gain_reg),
    .offset_trim_bits   (offset_reg),
    .code_out           (adjusted_code)
  );

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      voltage_output_enable  <= 1'b0;
      current_output_enable  <= 1'b0;
      voltage_range          <= 3'h0;
      current_range          <= 2'h0;
      sense_power_down       <= 1'b0;
      modem_coupling_active  <= 1'b0;
      timeout_monitor_enable <= 1'b0;
      timeout_period_select  <= 2'h0;
      converter_code         <= 16'h0000;
    end
    else
    begin
      // dual: both on; single: range top bit picks current vs voltage
      voltage_output_enable  <= control_reg[CTL_OUTPUT_EN_BIT] && (dual_on || !control_reg[CTL_RANGE_HI]);
      current_output_enable  <= control_reg[CTL_OUTPUT_EN_BIT] && (dual_on || control_reg[CTL_RANGE_HI]);
      voltage_range          <= control_reg[CTL_RANGE_HI:CTL_RANGE_LO];
      current_range          <= eff_cur_range;
      sense_power_down       <= config_reg[CFG_SENSE_PD_BIT];
      modem_coupling_active  <= config_reg[CFG_MODEM_EN_BIT]
                                && (dual_on || control_reg[CTL_RANGE_HI])
                                && eff_cur_range == CUR_RANGE_4_20;
      timeout_monitor_enable <= config_reg[CFG_TIMEOUT_EN_BIT];
      timeout_period_select  <= config_reg[1:0];
      converter_code         <= adjusted_code;
    end
  end
endmodule

// file: hw/dcrb_host.sv
// module: host controller issuing register write and readback frames
`timescale 1ns/100ps
module dcrb_host
  import dcrb_pkg::*;
(
  input  wire logic        clk,          // 50 MHz clock
  input  wire logic        reset_n,      // synchronous reset
  dcrb_link_if.host        link,         // frame link
  input  wire logic        cmd_valid,    // one-cycle request
  input  wire logic [7:0]  cmd_addr,     // target address
  input  wire logic [15:0] cmd_data,     // write data or readback selector
  input  wire logic        cmd_corrupt,  // mark frame as failing its check
  output logic             cmd_busy,     // request pending on link
  output logic             rsp_valid,    // readback strobe
  output logic [15:0]      rsp_data      // readback word
);
  // ****************************************************************
  // frame issue: one frame per accepted request
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      link.frame_valid <= 1'b0;
      link.frame_data  <= 24'h000000;
      link.frame_error <= 1'b0;
      cmd_busy         <= 1'b0;
    end
    else
    begin
      link.frame_valid <= cmd_valid && !cmd_busy;
      cmd_busy         <= cmd_valid && !cmd_busy;
      if (cmd_valid && !cmd_busy)
      begin
        // reserved configuration bits forced to zero
        link.frame_data  <= {cmd_addr, (cmd_addr == ADDR_DEVICE_CONFIG) ? (cmd_data & CFG_WRITE_MASK) : cmd_data};
        link.frame_error <= cmd_corrupt;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end
    else
    begin
      rsp_valid <= link.read_valid;
      if (link.read_valid)
        rsp_data <= link.read_data;
    end
  end
endmodule

// file: tb/dcrb_link_asserts.sv
// checker: protocol assertions on the frame link between host and register bank
`timescale 1ns/100ps
module dcrb_link_asserts
  import dcrb_pkg::*;
(
  input wire logic        clk,          // bank clock
  input wire logic        reset_n,      // synchronous reset, active low
  input wire logic        frame_valid,  // frame strobe
  input wire logic [23:0] frame_data,   // address and data
  input wire logic        frame_error,  // frame check failure, not judged here
  input wire logic [15:0] read_data,    // readback word
  input wire logic        read_valid    // readback strobe
);
  // ****************************************************************
  // sequences and properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rb_req;
    frame_valid && frame_data[23:16] == ADDR_READBACK;
  endsequence
  sequence rb_sel(logic [7:0] s);
    frame_valid && frame_data[23:16] == ADDR_READBACK && frame_data[7:0] == s;
  endsequence
  sequence soft_req;
    frame_valid && frame_data[23:16] == ADDR_SOFT_RESET && frame_data[0];
  endsequence
  chk_readback_answer: assert property (rb_req |=> read_valid)
    else $error("readback frame not answered next cycle");
  chk_answer_cause: assert property (read_valid |-> $past(frame_valid) && $past(frame_data[23:16]) == ADDR_READBACK)
    else $error("readback word without a readback frame");
  chk_answer_pulse: assert property (read_valid |=> !read_valid)
    else $error("readback strobe longer than one cycle");
  chk_frame_spacing: assert property (frame_valid |=> !frame_valid)
    else $error("frames sent back to back");
  chk_status_reserved: assert property (rb_sel(RB_STATUS) |=> read_data[15:5] == 11'h000 && !read_data[1])
    else $error("status reserved bits not zero");
  chk_config_reserved: assert property (rb_sel(RB_DEVICE_CONFIG) |=> (read_data & ~CFG_WRITE_MASK) == 16'h0000)
    else $error("configuration reserved bits not zero");
  chk_unknown_select: assert property (rb_sel(8'h05) |=> read_data == 16'h0000)
    else $error("unknown readback selector returned data");
  chk_read_hold: assert property (!read_valid |-> $stable(read_data))
    else $error("readback word changed without a read");
  chk_reset_quiet: assert property ($rose(reset_n) |-> !frame_valid && !read_valid)
    else $error("link active at reset release");
  chk_soft_reset_clear: assert property (soft_req ##[2:8] rb_sel(RB_OUTPUT_CONTROL) |=> read_data == CONTROL_RESET)
    else $error("control not cleared by software reset");
endmodule

// file: tb/dac_config_register_bank_test.sv
// testbench: host and register bank joined by the frame link, driven from the command side
`timescale 1ns/100ps
module dac_config_register_bank_test;
  import dcrb_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_addr = 8'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic        cmd_corrupt = 1'b0;
  logic        cmd_busy, rsp_valid, vo_en, co_en, sense_pd, modem_on, tmo_en;
  logic [15:0] rsp_data, code;
  logic [2:0]  v_range;
  logic [1:0]  c_range, tmo_sel;
  logic [4:0]  alarm;
  logic [2:0]  fault = 3'h0;
  int          err_total = 0;
  int          total_checks = 0;

  always #10 clk = ~clk;
  dcrb_link_if link ();
  dcrb_host dcrb_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_corrupt(cmd_corrupt), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  dcrb_device dcrb_device_inst (.clk(clk), .reset_n(reset_n), .link(link), .fault_current(fault[0]),
    .fault_thermal(fault[1]), .fault_timeout(fault[2]), .voltage_output_enable(vo_en), .current_output_enable(co_en),
    .voltage_range(v_range), .current_range(c_range), .sense_power_down(sense_pd), .modem_coupling_active(modem_on),
    .timeout_monitor_enable(tmo_en), .timeout_period_select(tmo_sel), .converter_code(code), .alarm_status(alarm));
  dcrb_link_asserts dcrb_link_asserts_inst (.clk(clk), .reset_n(reset_n), .frame_valid(link.frame_valid),
    .frame_data(link.frame_data), .frame_error(link.frame_error), .read_data(link.read_data),
    .read_valid(link.read_valid));

  // ****************************************************************
  // command-side tasks
  // ****************************************************************
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one cycle request; the host's busy cycle is covered by the caller's spacing
  task automatic issue(input logic [7:0] a, input logic [15:0] d, input logic c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    cmd_corrupt = c;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  // five cycles cover frame, register update and output update, soft reset included
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic c = 1'b0);
    issue(a, d, c);
    repeat (5) @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] sel, input logic [15:0] exp);
    int n;
    issue(ADDR_READBACK, {8'h00, sel}, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 10)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      chk(rsp_data, exp);
      @(negedge clk);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(code, CODE_RESET);
    rdchk(RB_OUTPUT_CODE, CODE_RESET);
    rdchk(RB_GAIN_CAL, CAL_RESET);
    rdchk(RB_OFFSET_CAL, CAL_RESET);
    rdchk(8'h05, 16'h0000);
    issue(8'h60, 16'h0000, 1'b0);
    chk(cmd_busy, 16'h0001);
    @(negedge clk);
    chk(cmd_busy, 16'h0000);
  endtask
  task automatic t_config;
    wr(ADDR_OUTPUT_CONTROL, 16'h1000);
    wr(ADDR_DEVICE_CONFIG, 16'h0387);
    chk({vo_en, co_en, sense_pd, tmo_en}, 16'h000f);
    chk({v_range, c_range, tmo_sel}, 16'h0007);
    rdchk(RB_DEVICE_CONFIG, 16'h0387);
    rdchk(RB_OUTPUT_CONTROL, 16'h1000);
    wr(ADDR_DEVICE_CONFIG, 16'h0000);
    chk({vo_en, co_en, sense_pd}, 16'h0004);
    wr(ADDR_OUTPUT_CONTROL, 16'h1005);
    wr(ADDR_DEVICE_CONFIG, 16'h0400);
    chk({vo_en, co_en, c_range}, 16'h0005);
  endtask
  task automatic t_code;
    wr(ADDR_OUTPUT_CONTROL, 16'h1000);
    wr(ADDR_DEVICE_CONFIG, 16'h0100);
    wr(ADDR_OUTPUT_CODE, 16'h1234);
    chk(code, 16'h1234);
    wr(ADDR_DEVICE_CONFIG, 16'h0300);
    chk(code, 16'h1234);
    wr(ADDR_OUTPUT_CONTROL, 16'h9001);
    rdchk(RB_OUTPUT_CODE, CODE_MIDSCALE);
    wr(ADDR_OUTPUT_CONTROL, 16'h1000);
    chk(code, CODE_ZERO);
  endtask
  task automatic t_cal;
    wr(ADDR_OUTPUT_CODE, 16'h1000);
    wr(ADDR_OFFSET_CAL, 16'h0010);
    chk(code, 16'h1000);
    wr(ADDR_DEVICE_CONFIG, 16'h0020);
    chk(code, 16'h1010);
    wr(ADDR_OFFSET_CAL, 16'hfff0);
    wr(ADDR_GAIN_CAL, 16'h8000);
    chk(code, 16'h17f0);
    rdchk(RB_GAIN_CAL, 16'h8000);
  endtask
  task automatic t_modem;
    wr(ADDR_DEVICE_CONFIG, 16'h0010);
    wr(ADDR_OUTPUT_CONTROL, {13'h0200, 1'b1, CUR_RANGE_4_20});
    chk(modem_on, 16'h0001);
    wr(ADDR_OUTPUT_CONTROL, 16'h1006);
    chk(modem_on, 16'h0000);
  endtask
  task automatic t_check;
    wr(ADDR_DEVICE_CONFIG, 16'h0008);
    wr(ADDR_GAIN_CAL, 16'h1111, 1'b1);
    chk(alarm, 16'h0010);
    rdchk(RB_STATUS, 16'h0010);
    rdchk(RB_GAIN_CAL, 16'h8000);
    chk(alarm, 16'h0000);
    wr(ADDR_DEVICE_CONFIG, 16'h0000);
    wr(ADDR_GAIN_CAL, 16'h2222, 1'b1);
    rdchk(RB_GAIN_CAL, 16'h2222);
  endtask
  task automatic t_soft;
    wr(ADDR_OUTPUT_CONTROL, 16'h1001);
    wr(ADDR_OUTPUT_CODE, 16'h4321);
    wr(8'h60, 16'hffff);
    wr(ADDR_SOFT_RESET, 16'hfffe);
    rdchk(RB_OUTPUT_CONTROL, 16'h1001);
    chk(code, 16'h4321);
    wr(ADDR_SOFT_RESET, 16'h0001);
    rdchk(RB_OUTPUT_CONTROL, CONTROL_RESET);
    rdchk(RB_DEVICE_CONFIG, CONFIG_RESET);
    rdchk(RB_GAIN_CAL, CAL_RESET);
    chk({vo_en, co_en, code}, 16'h0000);
    wr(ADDR_OUTPUT_CODE, 16'h0042);
    chk(code, 16'h0042);
  endtask
  task automatic t_fault;
    logic [4:0] bit_of [3] = '{5'h04, 5'h01, 5'h08};
    for (int i = 0; i < 3; i++)
    begin
      fault[i] = 1'b1;
      repeat (3) @(negedge clk);
      chk(alarm, {11'h000, bit_of[i]});
      fault[i] = 1'b0;
      repeat (3) @(negedge clk);
      chk(alarm, 16'h0000);
    end
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_config();
    t_code();
    t_cal();
    t_modem();
    t_check();
    t_soft();
    t_fault();
    conclude();
  end
endmodule
